/* File: rtl/monitor_pkg.sv */
// Constants and carrier types for the monitor select and detect threshold registers
// Overview of operation
// [RQ1] Pins one/two: code 000 low, 100 noise
// [RQ2] Code 001 signal found, 010 preamble found
// [RQ3] Code 011 strength found, 101 operating state
// [RQ4] Code 110 signal absent, 111 synth lock
// [RQ5] Host writes zero to bits 7 and 3
// [RQ6] Pins three/four live only in test
// [RQ7] Pin three analogue map, 110/111 low
// [RQ8] Pin four analogue map, 110/111 low
// [RQ9] Strength threshold eight bits, resets to zero
// [RQ10] Host picks threshold from strength level reading
// [RQ11] Preamble period nine bits, resets to 158
// [RQ12] Period used only with preamble detection on
// [RQ13] Tolerance seven bits, resets to 5, gated
// [RQ14] All bits read back last written value
package monitor_pkg;

    localparam logic [7:0] ADDR_MONITOR_SELECT_A             = 8'h14;
    localparam logic [7:0] ADDR_MONITOR_SELECT_B             = 8'h15;
    localparam logic [7:0] ADDR_RSSI_THRESHOLD               = 8'h16;
    localparam logic [7:0] ADDR_PREAMBLE_PERIOD_LOW          = 8'h17;
    localparam logic [7:0] ADDR_PREAMBLE_PERIOD_HIGH_MARGIN  = 8'h18;

    localparam logic [7:0] RESET_MONITOR_SELECT_A            = 8'h00;
    localparam logic [7:0] RESET_MONITOR_SELECT_B            = 8'h00;
    localparam logic [7:0] RESET_RSSI_THRESHOLD              = 8'h00;
    localparam logic [7:0] RESET_PREAMBLE_PERIOD_LOW         = 8'h9E;
    localparam logic [7:0] RESET_PREAMBLE_PERIOD_HIGH_MARGIN = 8'h05;

    // Field positions: upper selector, lower selector, period top bit
    localparam int SEL_UPPER_LSB   = 4;
    localparam int SEL_LOWER_LSB   = 0;
    localparam int SEL_WIDTH       = 3;
    localparam int PERIOD_TOP_BIT  = 7;
    localparam int TOLERANCE_WIDTH = 7;
    localparam int PERIOD_WIDTH    = 9;

    typedef enum logic [2:0] {
        ANA_CODE_0 = 3'h0,
        ANA_CODE_1 = 3'h1,
        ANA_CODE_2 = 3'h2,
        ANA_CODE_3 = 3'h3,
        ANA_CODE_4 = 3'h4,
        ANA_CODE_5 = 3'h5
    } analog_code_t;

    // Order matters: index = selector code once a zero is appended
    typedef struct packed {
        logic synth_lock_flag;
        logic signal_absent;
        logic operating_state_flag;
        logic noise_found;
        logic strength_found;
        logic preamble_found;
        logic signal_found;
    } detect_bus_t;

    // Analogue test levels carried as 8-bit samples
    typedef struct packed {
        logic [7:0] rate_filter_output;
        logic [7:0] rate_filter_input;
        logic [7:0] slicer_reference;
        logic [7:0] strength_level_voltage;
        logic [7:0] noise_level_voltage;
        logic [7:0] peak_hold_voltage;
    } analog_bus_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_t;

    typedef struct packed {
        logic [7:0]                   monitor_select_a;
        logic [7:0]                   monitor_select_b;
        logic [7:0]                   rssi_threshold;
        logic [7:0]                   preamble_period_low;
        logic [7:0]                   preamble_period_high_margin;
        logic [7:0]                   rd_data;
        logic                         probe_pin_one;
        logic                         probe_pin_two;
        logic [7:0]                   probe_pin_three;
        logic [7:0]                   probe_pin_four;
        logic [PERIOD_WIDTH-1:0]      preamble_period;
        logic [TOLERANCE_WIDTH-1:0]   preamble_tolerance;
        logic                         armed;
    } bank_state_t;

endpackage

/* File: rtl/probe_router.sv */
// Combinational routing of internal results and test levels to the four probe pins
`timescale 1ns/1ns
`default_nettype none
module probe_router (
    input  wire logic [7:0]               monitor_select_a,
    input  wire logic [7:0]               monitor_select_b,
    input  wire logic                     test_active,
    input  wire monitor_pkg::detect_bus_t detect,
    input  wire monitor_pkg::analog_bus_t analog,
    output logic      [1:0]               digital_pin,
    output logic      [7:0]               pin_three,
    output logic      [7:0]               pin_four
);

    logic [7:0] detect_table;
    logic [5:0] code_digital;

    // Code zero lands on the appended constant low
    assign detect_table = {detect, 1'b0};
    assign code_digital = {monitor_select_a[monitor_pkg::SEL_UPPER_LSB +: monitor_pkg::SEL_WIDTH],
                           monitor_select_a[monitor_pkg::SEL_LOWER_LSB +: monitor_pkg::SEL_WIDTH]};

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_digital
            // Pin one takes the upper selector, pin two the lower
            assign digital_pin[g] = detect_table[code_digital[(1 - g) * 3 +: 3]]; // [RQ1] [RQ2] [RQ3] [RQ4]
        end
    endgenerate

    // Codes 0 and 2 swap between the two pins; 1 and 3..5 are shared, rest low
    function automatic logic [7:0] analog_pick(input logic [2:0] code, input logic swap,
                                               input monitor_pkg::analog_bus_t a);
        logic [7:0] v;
        v = 8'h00;
        case (code)
            monitor_pkg::ANA_CODE_0: v = swap ? a.slicer_reference : a.rate_filter_output;
            monitor_pkg::ANA_CODE_1: v = a.rate_filter_input;
            monitor_pkg::ANA_CODE_2: v = swap ? a.rate_filter_output : a.slicer_reference;
            monitor_pkg::ANA_CODE_3: v = a.strength_level_voltage;
            monitor_pkg::ANA_CODE_4: v = a.noise_level_voltage;
            monitor_pkg::ANA_CODE_5: v = a.peak_hold_voltage;
            default:                 v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb
    begin
        pin_three = 8'h00;
        pin_four  = 8'h00;
        if (test_active) // [RQ6]
        begin
            pin_three = analog_pick(monitor_select_b[monitor_pkg::SEL_UPPER_LSB +: monitor_pkg::SEL_WIDTH],
                                    1'b0, analog); // [RQ7]
            pin_four  = analog_pick(monitor_select_b[monitor_pkg::SEL_LOWER_LSB +: monitor_pkg::SEL_WIDTH],
                                    1'b1, analog); // [RQ8]
        end
    end

endmodule
`default_nettype wire

/* File: rtl/monitor_bank.sv */
// Monitor select and detection threshold register bank with probe pin outputs
`timescale 1ns/1ns
`default_nettype none
module monitor_bank (
    input  wire logic                     core_clk,
    input  wire logic                     reset_n,
    input  wire monitor_pkg::reg_req_t    reg_req,
    output logic      [7:0]               reg_rd_data,
    input  wire logic                     user_test_enable,
    input  wire logic                     test_mode_pin,
    input  wire logic                     preamble_enable,
    input  wire monitor_pkg::detect_bus_t detect,
    input  wire monitor_pkg::analog_bus_t analog,
    output logic                          probe_pin_one,
    output logic                          probe_pin_two,
    output logic      [7:0]               probe_pin_three,
    output logic      [7:0]               probe_pin_four,
    output logic      [7:0]               strength_threshold,
    output logic      [8:0]               preamble_period,
    output logic      [6:0]               preamble_tolerance
);

    monitor_pkg::bank_state_t st;
    monitor_pkg::bank_state_t next_st;

    logic [1:0] routed_digital;
    logic [7:0] routed_three;
    logic [7:0] routed_four;
    logic       test_active;

    assign test_active = user_test_enable | test_mode_pin; // [RQ6]

    // Read and write share one decoder
    function automatic logic [4:0] addr_hit(input logic [7:0] addr);
        addr_hit = {addr == monitor_pkg::ADDR_PREAMBLE_PERIOD_HIGH_MARGIN,
                    addr == monitor_pkg::ADDR_PREAMBLE_PERIOD_LOW,
                    addr == monitor_pkg::ADDR_RSSI_THRESHOLD,
                    addr == monitor_pkg::ADDR_MONITOR_SELECT_B,
                    addr == monitor_pkg::ADDR_MONITOR_SELECT_A};
    endfunction

    probe_router u_router (
        .monitor_select_a (st.monitor_select_a),
        .monitor_select_b (st.monitor_select_b),
        .test_active      (test_active),
        .detect           (detect),
        .analog           (analog),
        .digital_pin      (routed_digital),
        .pin_three        (routed_three),
        .pin_four         (routed_four)
    );

    always_comb
    begin
        logic [4:0] wr_hit;
        logic [4:0] rd_hit;
        wr_hit  = reg_req.wr ? addr_hit(reg_req.addr) : 5'h00;
        rd_hit  = addr_hit(reg_req.addr);
        next_st = st;
        next_st.armed = 1'b1;

        // Whole byte stored, reserved bits included, so readback is exact
        if (wr_hit[0])
            next_st.monitor_select_a = reg_req.data; // [RQ1] [RQ14]
        if (wr_hit[1])
            next_st.monitor_select_b = reg_req.data; // [RQ14]
        if (wr_hit[2])
            next_st.rssi_threshold = reg_req.data; // [RQ9]
        if (wr_hit[3])
            next_st.preamble_period_low = reg_req.data; // [RQ11]
        if (wr_hit[4])
            next_st.preamble_period_high_margin = reg_req.data; // [RQ11] [RQ13]

        // Unmapped reads answer zero
        if (reg_req.rd)
        begin
            next_st.rd_data = 8'h00;
            case (1'b1)
                rd_hit[0]: next_st.rd_data = st.monitor_select_a; // [RQ14]
                rd_hit[1]: next_st.rd_data = st.monitor_select_b; // [RQ14]
                rd_hit[2]: next_st.rd_data = st.rssi_threshold; // [RQ14]
                rd_hit[3]: next_st.rd_data = st.preamble_period_low; // [RQ14]
                rd_hit[4]: next_st.rd_data = st.preamble_period_high_margin; // [RQ14]
                default:   next_st.rd_data = 8'h00;
            endcase
        end

        next_st.probe_pin_one   = routed_digital[0];
        next_st.probe_pin_two   = routed_digital[1];
        next_st.probe_pin_three = routed_three;
        next_st.probe_pin_four  = routed_four;

        // Detector sees zeros while off, so a stale setting cannot leak in
        if (preamble_enable) // [RQ12]
        begin
            next_st.preamble_period    = {st.preamble_period_high_margin[monitor_pkg::PERIOD_TOP_BIT],
                                          st.preamble_period_low}; // [RQ11]
            next_st.preamble_tolerance = st.preamble_period_high_margin[monitor_pkg::TOLERANCE_WIDTH-1:0]; // [RQ13]
        end
        else
        begin
            next_st.preamble_period    = '0;
            next_st.preamble_tolerance = '0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st                             <= '0;
            st.monitor_select_a            <= monitor_pkg::RESET_MONITOR_SELECT_A;
            st.monitor_select_b            <= monitor_pkg::RESET_MONITOR_SELECT_B;
            st.rssi_threshold              <= monitor_pkg::RESET_RSSI_THRESHOLD; // [RQ9]
            st.preamble_period_low         <= monitor_pkg::RESET_PREAMBLE_PERIOD_LOW; // [RQ11]
            st.preamble_period_high_margin <= monitor_pkg::RESET_PREAMBLE_PERIOD_HIGH_MARGIN; // [RQ13]
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rd_data        = st.rd_data;
    assign probe_pin_one      = st.probe_pin_one;
    assign probe_pin_two      = st.probe_pin_two;
    assign probe_pin_three    = st.probe_pin_three;
    assign probe_pin_four     = st.probe_pin_four;
    assign strength_threshold = st.rssi_threshold;
    assign preamble_period    = st.preamble_period;
    assign preamble_tolerance = st.preamble_tolerance;

    // Checks on the bank's own outputs
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    logic [2:0] sel_one;
    logic [2:0] sel_two;
    logic [2:0] sel_three;
    logic [2:0] sel_four;
    assign sel_one   = st.monitor_select_a[6:4];
    assign sel_two   = st.monitor_select_a[2:0];
    assign sel_three = st.monitor_select_b[6:4];
    assign sel_four  = st.monitor_select_b[2:0];

    sequence write_to(logic [7:0] a);
        reg_req.wr && reg_req.addr == a;
    endsequence

    sequence quiet_read_of(logic [7:0] a);
        reg_req.rd && !reg_req.wr && reg_req.addr == a;
    endsequence

    chk_pin_low_code: assert property ( // [RQ1]
        st.armed && sel_one == 3'h0 |=> !probe_pin_one)
        else $error("pin one not low for code zero");

    chk_pin_noise_route: assert property ( // [RQ1]
        st.armed && sel_one == 3'h4 |=> probe_pin_one == $past(detect.noise_found))
        else $error("pin one does not follow noise result");

    chk_detect_preamble_route: assert property ( // [RQ2]
        st.armed && (sel_two == 3'h1 || sel_two == 3'h2) |=>
        probe_pin_two == ($past(sel_two) == 3'h1 ? $past(detect.signal_found) : $past(detect.preamble_found)))
        else $error("pin two wrong for codes one or two");

    chk_strength_state_route: assert property ( // [RQ3]
        st.armed && (sel_one == 3'h3 || sel_one == 3'h5) |=>
        probe_pin_one == ($past(sel_one) == 3'h3 ? $past(detect.strength_found)
                                                 : $past(detect.operating_state_flag)))
        else $error("pin one wrong for codes three or five");

    chk_absent_lock_route: assert property ( // [RQ4]
        st.armed && sel_two[2:1] == 2'b11 |=>
        probe_pin_two == ($past(sel_two[0]) ? $past(detect.synth_lock_flag) : $past(detect.signal_absent)))
        else $error("pin two wrong for codes six or seven");

    chk_test_gate_low: assert property ( // [RQ6]
        st.armed && !user_test_enable && !test_mode_pin |=> probe_pin_three == 8'h00 && probe_pin_four == 8'h00)
        else $error("analogue pins driven outside test");

    chk_pin_three_map: assert property ( // [RQ7]
        st.armed && test_active && sel_three == 3'h0 ##1 1'b1 |->
        probe_pin_three == $past(analog.rate_filter_output))
        else $error("pin three code zero wrong");

    chk_pin_four_map: assert property ( // [RQ8]
        st.armed && test_active && sel_four == 3'h2 |=> probe_pin_four == $past(analog.rate_filter_output))
        else $error("pin four code two wrong");

    chk_analog_high_low: assert property ( // [RQ7]
        st.armed && sel_three[2:1] == 2'b11 && sel_four[2:1] == 2'b11 |=>
        probe_pin_three == 8'h00 && probe_pin_four == 8'h00)
        else $error("analogue pins not low for codes six and seven");

    chk_threshold_write: assert property ( // [RQ9]
        write_to(monitor_pkg::ADDR_RSSI_THRESHOLD) |=> strength_threshold == $past(reg_req.data))
        else $error("threshold not loaded by write");

    chk_period_join: assert property ( // [RQ11]
        st.armed && preamble_enable |=>
        preamble_period == {$past(st.preamble_period_high_margin[7]), $past(st.preamble_period_low)})
        else $error("period not joined from both registers");

    chk_period_ignored: assert property ( // [RQ12]
        st.armed && !preamble_enable |=> preamble_period == 9'h000 && preamble_tolerance == 7'h00)
        else $error("preamble settings leak while disabled");

    chk_tolerance_field: assert property ( // [RQ13]
        st.armed && preamble_enable |=> preamble_tolerance == $past(st.preamble_period_high_margin[6:0]))
        else $error("tolerance field wrong");

    chk_select_readback: assert property ( // [RQ14]
        write_to(monitor_pkg::ADDR_MONITOR_SELECT_B) ##1 quiet_read_of(monitor_pkg::ADDR_MONITOR_SELECT_B) |=>
        reg_rd_data == $past(reg_req.data, 2))
        else $error("select register readback mismatch");

    chk_unmapped_read: assert property ( // [RQ14]
        reg_req.rd && addr_hit(reg_req.addr) == 5'h00 |=> reg_rd_data == 8'h00)
        else $error("unmapped read not zero");

endmodule
`default_nettype wire

/* File: test/host_model.sv */
// Host controller model driving the register strobe port of the bank
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic                  core_clk,
    input  wire logic [7:0]            reg_rd_data,
    output var  monitor_pkg::reg_req_t reg_req
);
    initial reg_req = '0;

    // Released address and data show the inverse, so a stale value never passes
    task automatic issue(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_req <= '{wr: wr, rd: rd, addr: addr, data: data};
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == monitor_pkg::ADDR_MONITOR_SELECT_A || addr == monitor_pkg::ADDR_MONITOR_SELECT_B)
        begin
            d = data & 8'h77;
        end
        issue(1'b1, 1'b0, addr, d);
    endtask

    // Answer holds until the next read, so one spare cycle costs nothing
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        issue(1'b0, 1'b1, addr, 8'h00);
        @(posedge core_clk);
        @(negedge core_clk);
        data = reg_rd_data;
    endtask

    // Select register written, then read on the very next edge, as the port allows
    task automatic write_then_read(input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, data: wdata & 8'h77};
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, data: 8'h00};
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: 8'hFF};
        @(negedge core_clk);
        rdata = reg_rd_data;
    endtask

    // Threshold placed a fixed margin above the level reading
    task automatic tune_threshold(input logic [7:0] level, input logic [7:0] margin);
        write_reg(monitor_pkg::ADDR_RSSI_THRESHOLD, level + margin);
    endtask
endmodule
`default_nettype wire

/* File: test/monitor_select_and_detect_thresholds_tb.sv */
// Self-checking bench for the monitor select and detect threshold bank
`timescale 1ns/1ns
`default_nettype none
module monitor_select_and_detect_thresholds_tb;
    typedef struct packed {
        logic [7:0] sel;
        logic [6:0] det;
        logic       hit;
        logic [7:0] lvl_three;
        logic [7:0] lvl_four;
    } row_t;

    logic                     core_clk         = 1'b0;
    logic                     reset_n          = 1'b0;
    monitor_pkg::reg_req_t    reg_req;
    logic [7:0]               reg_rd_data;
    logic                     user_test_enable = 1'b1;
    logic                     test_mode_pin    = 1'b0;
    logic                     preamble_enable  = 1'b0;
    monitor_pkg::detect_bus_t detect           = '0;
    monitor_pkg::analog_bus_t analog           = 48'hA1B2C3D4E5F6;
    logic                     probe_pin_one;
    logic                     probe_pin_two;
    logic [7:0]               probe_pin_three;
    logic [7:0]               probe_pin_four;
    logic [7:0]               strength_threshold;
    logic [8:0]               preamble_period;
    logic [6:0]               preamble_tolerance;
    logic [7:0]               rd_back;
    int                       n_mismatch       = 0;
    int                       comparisons      = 0;
    // One-hot detect per code, all ones for code zero; inverted pattern must then give low
    row_t                     rows [8]         = '{
        '{8'h00, 7'h7F, 1'b0, 8'hA1, 8'hC3}, '{8'h11, 7'h01, 1'b1, 8'hB2, 8'hB2},
        '{8'h22, 7'h02, 1'b1, 8'hC3, 8'hA1}, '{8'h33, 7'h04, 1'b1, 8'hD4, 8'hD4},
        '{8'h44, 7'h08, 1'b1, 8'hE5, 8'hE5}, '{8'h55, 7'h10, 1'b1, 8'hF6, 8'hF6},
        '{8'h66, 7'h20, 1'b1, 8'h00, 8'h00}, '{8'h77, 7'h40, 1'b1, 8'h00, 8'h00}};

    always #20 core_clk = ~core_clk;

    monitor_bank i_monitor_bank (
        .core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
        .user_test_enable(user_test_enable), .test_mode_pin(test_mode_pin), .preamble_enable(preamble_enable),
        .detect(detect), .analog(analog), .probe_pin_one(probe_pin_one), .probe_pin_two(probe_pin_two),
        .probe_pin_three(probe_pin_three), .probe_pin_four(probe_pin_four),
        .strength_threshold(strength_threshold), .preamble_period(preamble_period),
        .preamble_tolerance(preamble_tolerance)
    );

    host_model i_host_model (.core_clk(core_clk), .reg_rd_data(reg_rd_data), .reg_req(reg_req));

    task automatic test_done;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check_out(input logic [8:0] got, input logic [8:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        i_host_model.read_reg(addr, d);
        check_out(9'(d), 9'(exp), "register read");
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_host_model.write_reg(addr, data);
    endtask

    // Select writes reach the pins one cycle after being taken
    task automatic settle;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        test_done();
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        check_reg(monitor_pkg::ADDR_MONITOR_SELECT_A, 8'h00);
        check_reg(monitor_pkg::ADDR_MONITOR_SELECT_B, 8'h00);
        check_reg(monitor_pkg::ADDR_RSSI_THRESHOLD, 8'h00);
        check_reg(monitor_pkg::ADDR_PREAMBLE_PERIOD_LOW, 8'h9E);
        check_reg(monitor_pkg::ADDR_PREAMBLE_PERIOD_HIGH_MARGIN, 8'h05);
        check_out(9'(strength_threshold), 9'h000, "threshold");
        check_out(preamble_period, 9'h000, "period gated");
        @(posedge core_clk);
        preamble_enable <= 1'b1;
        settle();
        check_out(preamble_period, 9'h09E, "period");
        check_out(9'(preamble_tolerance), 9'h005, "tolerance");
        for (int k = 0; k < 8; k++)
        begin
            wr(monitor_pkg::ADDR_MONITOR_SELECT_A, rows[k].sel);
            wr(monitor_pkg::ADDR_MONITOR_SELECT_B, rows[k].sel);
            detect <= rows[k].det;
            settle();
            check_out(9'(probe_pin_one), 9'(rows[k].hit), "pin one");
            check_out(9'(probe_pin_two), 9'(rows[k].hit), "pin two");
            check_out(9'(probe_pin_three), 9'(rows[k].lvl_three), "pin three");
            check_out(9'(probe_pin_four), 9'(rows[k].lvl_four), "pin four");
            @(posedge core_clk);
            detect <= ~rows[k].det;
            settle();
            check_out(9'(probe_pin_one), 9'h000, "pin one other");
            check_out(9'(probe_pin_two), 9'h000, "pin two other");
        end
        wr(monitor_pkg::ADDR_MONITOR_SELECT_A, 8'hFF);
        check_reg(monitor_pkg::ADDR_MONITOR_SELECT_A, 8'h77);
        wr(monitor_pkg::ADDR_MONITOR_SELECT_A, 8'h40);
        detect <= 7'h7F;
        settle();
        check_out(9'(probe_pin_one), 9'h001, "pin one noise");
        check_out(9'(probe_pin_two), 9'h000, "pin two low");
        wr(monitor_pkg::ADDR_MONITOR_SELECT_B, 8'h22);
        user_test_enable <= 1'b0;
        settle();
        check_out(9'(probe_pin_three), 9'h000, "pin three idle");
        check_out(9'(probe_pin_four), 9'h000, "pin four idle");
        @(posedge core_clk);
        test_mode_pin <= 1'b1;
        settle();
        check_out(9'(probe_pin_three), 9'h0C3, "pin three test");
        check_out(9'(probe_pin_four), 9'h0A1, "pin four test");
        i_host_model.tune_threshold(8'hD4, 8'h2B);
        settle();
        check_out(9'(strength_threshold), 9'h0FF, "threshold max");
        check_reg(monitor_pkg::ADDR_RSSI_THRESHOLD, 8'hFF);
        wr(monitor_pkg::ADDR_PREAMBLE_PERIOD_LOW, 8'hFF);
        wr(monitor_pkg::ADDR_PREAMBLE_PERIOD_HIGH_MARGIN, 8'hFF);
        settle();
        check_out(preamble_period, 9'h1FF, "period max");
        check_out(9'(preamble_tolerance), 9'h07F, "tolerance max");
        @(posedge core_clk);
        preamble_enable <= 1'b0;
        settle();
        check_out(9'(preamble_tolerance), 9'h000, "tolerance gated");
        check_reg(monitor_pkg::ADDR_PREAMBLE_PERIOD_HIGH_MARGIN, 8'hFF);
        i_host_model.write_then_read(monitor_pkg::ADDR_MONITOR_SELECT_B, 8'hDA, rd_back);
        check_out(9'(rd_back), 9'h052, "write then read");
        wr(8'h19, 8'h5A);
        check_reg(8'h19, 8'h00);
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        check_reg(monitor_pkg::ADDR_PREAMBLE_PERIOD_LOW, 8'h9E);
        check_reg(monitor_pkg::ADDR_RSSI_THRESHOLD, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
